// ---- src/tjmd_core.v ----
// jump and move instruction decoder/executor with axi4-lite command port
`timescale 1ns/1ns
`default_nettype none
`include "tjmd_map.vh"
module tjmd_core (
	input wire mclk,
	input wire rst_n,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire timer_overflow_set,
	input wire external_interrupt_pin,
	input wire [15:0] cursor_address_reg,
	input wire [15:0] home_address_reg,
	input wire [6:0] horizontal_pen_position,
	input wire [4:0] vertical_pen_position,
	input wire [5:0] serial_status_latch,
	input wire [7:0] interrupt_pending_reg,
	input wire [7:0] program_status_word,
	input wire [7:0] timer_count,
	output reg cursor_wr_q,
	output reg home_wr_q,
	output reg display_memory_start_wr_q,
	output reg [15:0] pair_wdata_q,
	output reg attribute_latch_zero_wr_q,
	output reg attribute_latch_one_wr_q,
	output reg baud_select_wr_q,
	output reg [7:0] byte_wdata_q
);
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_EXEC = 2'd1;
	localparam [1:0] S_EXEC2 = 2'd2;
	localparam [1:0] S_MEMRD = 2'd3;

	// ****************************************************************
	// functions
	// ****************************************************************
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	function is_jump;
		input [7:0] op;
		begin
			case (op)
			`TJMD_OP_JMP_TCLR, `TJMD_OP_JMP_TSET, `TJMD_OP_JMP_AZ, `TJMD_OP_JMP_ANZ,
			`TJMD_OP_JF0, `TJMD_OP_JNF0, `TJMD_OP_JF1, `TJMD_OP_JNF1, `TJMD_OP_JXI,
			`TJMD_OP_JNXI: is_jump = 1'b1;
			default: is_jump = 1'b0;
			endcase
		end
	endfunction

	function jump_go;
		input [7:0] op;
		input tmr;
		input uf0;
		input uf1;
		input xpin;
		input [7:0] a;
		begin
			case (op)
			`TJMD_OP_JMP_TCLR: jump_go = ~tmr;
			`TJMD_OP_JMP_TSET: jump_go = tmr;
			`TJMD_OP_JMP_AZ: jump_go = (a == 8'h00);
			`TJMD_OP_JMP_ANZ: jump_go = (a != 8'h00);
			`TJMD_OP_JF0: jump_go = uf0;
			`TJMD_OP_JNF0: jump_go = ~uf0;
			`TJMD_OP_JF1: jump_go = uf1;
			`TJMD_OP_JNF1: jump_go = ~uf1;
			`TJMD_OP_JXI: jump_go = xpin;
			`TJMD_OP_JNXI: jump_go = ~xpin;
			default: jump_go = 1'b0;
			endcase
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	reg [1:0] state_q, state_d;
	reg [7:0] op_q, op_d;
	reg [7:0] arg_q, arg_d;
	reg [12:0] pc_q, pc_d;
	reg [7:0] acc_q, acc_d;
	reg [7:0] upper_accumulator_q, upper_accumulator_d;
	reg timer_overflow_flag_q, timer_overflow_flag_d;
	reg user_flag_zero_q, user_flag_zero_d;
	reg user_flag_one_q, user_flag_one_d;
	reg upper_flag_q, upper_flag_d;
	reg illegal_q, illegal_d;
	reg [63:0] working_register_q, working_register_d;
	reg cursor_wr_d, home_wr_d, display_memory_start_wr_d;
	reg attribute_latch_zero_wr_d, attribute_latch_one_wr_d, baud_select_wr_d;
	reg pin_meta_q, pin_sync_q;
	reg dmem_we;
	reg [31:0] rd_data;
	reg rd_ok;
	reg wr_ok;

	wire wr_en;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [11:0] rd_addr;
	wire [7:0] dmem_rdata;
	wire [7:0] ind_ptr;
	wire [31:0] wr_acc;
	wire [31:0] wr_pc;
	wire [31:0] wr_flags;
	wire [31:0] wr_wreg;
	wire [31:0] wr_cmd;
	wire [5:0] wreg_bit;

	// ****************************************************************
	// bus front end and data memory
	// ****************************************************************
	tjmd_axil u_axil (
		.mclk(mclk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// pointer is working register zero or one, chosen by opcode bit 0
	assign ind_ptr = working_register_q[{2'b00, op_q[0], 3'b000} +: 8];
	assign wreg_bit = {wr_addr[4:2], 3'b000};

	tjmd_dmem u_dmem (
		.mclk(mclk),
		.we(dmem_we),
		.waddr(wr_addr[7:2]),
		.wdata(wr_data[7:0]),
		.raddr(ind_ptr[5:0]),
		.rdata_q(dmem_rdata)
	);

	// ****************************************************************
	// register map decode
	// ****************************************************************
	assign wr_cmd = merge(32'h0000_0000, wr_data, wr_strb);
	assign wr_pc = merge({19'h00000, pc_q}, wr_data, wr_strb);
	assign wr_acc = merge({16'h0000, upper_accumulator_q, acc_q}, wr_data, wr_strb);
	assign wr_flags = merge({30'h0, user_flag_one_q, user_flag_zero_q}, wr_data, wr_strb);
	assign wr_wreg = merge({24'h000000, working_register_q[wreg_bit +: 8]}, wr_data, wr_strb);

	always @* begin
		rd_ok = 1'b1;
		rd_data = 32'h0000_0000;
		case (rd_addr)
		`TJMD_OFF_CMD: rd_data = {16'h0000, arg_q, op_q};
		`TJMD_OFF_STATUS: begin
			rd_data[`TJMD_ST_BUSY] = (state_q != S_IDLE);
			rd_data[`TJMD_ST_TMRF] = timer_overflow_flag_q;
			rd_data[`TJMD_ST_UF0] = user_flag_zero_q;
			rd_data[`TJMD_ST_UF1] = user_flag_one_q;
			rd_data[`TJMD_ST_HFLAG] = upper_flag_q;
			rd_data[`TJMD_ST_XPIN] = pin_sync_q;
			rd_data[`TJMD_ST_ILLEGAL] = illegal_q;
		end
		`TJMD_OFF_PC: rd_data = {19'h00000, pc_q};
		`TJMD_OFF_ACC: rd_data = {16'h0000, upper_accumulator_q, acc_q};
		`TJMD_OFF_FLAGS: rd_data = {30'h0, user_flag_one_q, user_flag_zero_q};
		default: begin
			if (rd_addr >= `TJMD_OFF_WREG && rd_addr <= `TJMD_OFF_WREG_END &&
			    rd_addr[1:0] == 2'b00) begin
				rd_data = {24'h000000, working_register_q[{rd_addr[4:2], 3'b000} +: 8]};
			end else if (rd_addr >= `TJMD_OFF_DMEM && rd_addr <= `TJMD_OFF_DMEM_END &&
			    rd_addr[1:0] == 2'b00) begin
				// data memory is write-only from the bus; its read port belongs to the core
				rd_data = 32'h0000_0000;
			end else begin
				rd_ok = 1'b0;
			end
		end
		endcase
	end

	always @* begin
		wr_ok = (wr_addr == `TJMD_OFF_CMD) || (wr_addr == `TJMD_OFF_STATUS) ||
		    (wr_addr == `TJMD_OFF_PC) || (wr_addr == `TJMD_OFF_ACC) ||
		    (wr_addr == `TJMD_OFF_FLAGS) ||
		    (wr_addr >= `TJMD_OFF_WREG && wr_addr <= `TJMD_OFF_WREG_END &&
		    wr_addr[1:0] == 2'b00) ||
		    (wr_addr >= `TJMD_OFF_DMEM && wr_addr <= `TJMD_OFF_DMEM_END &&
		    wr_addr[1:0] == 2'b00);
	end

	// ****************************************************************
	// decode and execute
	// ****************************************************************
	always @* begin
		state_d = state_q;
		op_d = op_q;
		arg_d = arg_q;
		pc_d = pc_q;
		acc_d = acc_q;
		upper_accumulator_d = upper_accumulator_q;
		timer_overflow_flag_d = timer_overflow_flag_q;
		user_flag_zero_d = user_flag_zero_q;
		user_flag_one_d = user_flag_one_q;
		upper_flag_d = upper_flag_q;
		illegal_d = illegal_q;
		working_register_d = working_register_q;
		cursor_wr_d = 1'b0;
		home_wr_d = 1'b0;
		display_memory_start_wr_d = 1'b0;
		attribute_latch_zero_wr_d = 1'b0;
		attribute_latch_one_wr_d = 1'b0;
		baud_select_wr_d = 1'b0;
		dmem_we = 1'b0;
		case (state_q)
		S_IDLE: begin
			// writes while busy are acknowledged but dropped, so the bus never races the core
			if (wr_en && wr_ok) begin
				if (wr_addr == `TJMD_OFF_CMD) begin
					op_d = wr_cmd[7:0];
					arg_d = wr_cmd[15:8];
					illegal_d = 1'b0;
					state_d = S_EXEC;
				end else if (wr_addr == `TJMD_OFF_PC) begin
					pc_d = wr_pc[12:0];
				end else if (wr_addr == `TJMD_OFF_ACC) begin
					acc_d = wr_acc[7:0];
					upper_accumulator_d = wr_acc[15:8];
				end else if (wr_addr == `TJMD_OFF_FLAGS) begin
					user_flag_zero_d = wr_flags[`TJMD_FL_UF0];
					user_flag_one_d = wr_flags[`TJMD_FL_UF1];
				end else if (wr_addr >= `TJMD_OFF_DMEM) begin
					dmem_we = 1'b1;
				end else if (wr_addr >= `TJMD_OFF_WREG) begin
					working_register_d[wreg_bit +: 8] = wr_wreg[7:0];
				end
			end
		end
		S_EXEC: begin
			state_d = S_IDLE;
			pc_d = pc_q + 13'd1;
			if (is_jump(op_q) || op_q == `TJMD_OP_A_IMM) begin
				// second cycle fetches the operand byte
				state_d = S_EXEC2;
				pc_d = pc_q;
			end else if (op_q[7:3] == `TJMD_OP_A_WREG_HI) begin
				acc_d = working_register_q[{op_q[2:0], 3'b000} +: 8];
			end else if (op_q[7:1] == `TJMD_OP_A_IND_HI) begin
				// memory read data is registered, so the load lands one edge later
				state_d = S_MEMRD;
				pc_d = pc_q;
			end else begin
				case (op_q)
				`TJMD_OP_A_CURSOR: begin
					{upper_accumulator_d, acc_d} = cursor_address_reg;
					upper_flag_d = (cursor_address_reg[15:8] != 8'h00);
				end
				`TJMD_OP_A_HOME: begin
					{upper_accumulator_d, acc_d} = home_address_reg;
					upper_flag_d = (home_address_reg[15:8] != 8'h00);
				end
				`TJMD_OP_CURSOR_A: cursor_wr_d = 1'b1;
				`TJMD_OP_HOME_A: home_wr_d = 1'b1;
				`TJMD_OP_DSTART_A: display_memory_start_wr_d = 1'b1;
				`TJMD_OP_A_UPPER: acc_d = upper_accumulator_q;
				`TJMD_OP_A_HPOS: acc_d = {1'b0, horizontal_pen_position};
				`TJMD_OP_A_VPOS: acc_d = {3'b000, vertical_pen_position};
				`TJMD_OP_A_STAT: acc_d = {2'b11, serial_status_latch};
				`TJMD_OP_A_IRQ: acc_d = interrupt_pending_reg;
				`TJMD_OP_A_STW: acc_d = program_status_word;
				`TJMD_OP_A_T: acc_d = timer_count;
				`TJMD_OP_ATTR0_A: attribute_latch_zero_wr_d = 1'b1;
				`TJMD_OP_ATTR1_A: attribute_latch_one_wr_d = 1'b1;
				`TJMD_OP_BAUD_A: baud_select_wr_d = 1'b1;
				default: begin
					illegal_d = 1'b1;
					pc_d = pc_q;
				end
				endcase
			end
		end
		S_EXEC2: begin
			state_d = S_IDLE;
			pc_d = pc_q + 13'd2;
			if (op_q == `TJMD_OP_A_IMM) begin
				acc_d = arg_q;
			end else begin
				if (jump_go(op_q, timer_overflow_flag_q, user_flag_zero_q, user_flag_one_q,
				    pin_sync_q, acc_q)) begin
					pc_d = {pc_q[12:8], arg_q};
				end
				// both timer jumps consume a set flag, one on fall-through, one on taken
				if ((op_q == `TJMD_OP_JMP_TCLR || op_q == `TJMD_OP_JMP_TSET) &&
				    timer_overflow_flag_q) begin
					timer_overflow_flag_d = 1'b0;
				end
			end
		end
		S_MEMRD: begin
			state_d = S_IDLE;
			acc_d = dmem_rdata;
			pc_d = pc_q + 13'd1;
		end
		default: state_d = S_IDLE;
		endcase
		// an overflow in the clearing cycle must not be lost
		if (timer_overflow_set) begin
			timer_overflow_flag_d = 1'b1;
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			op_q <= `TJMD_RST_BYTE;
			arg_q <= `TJMD_RST_BYTE;
			pc_q <= `TJMD_RST_PC;
			acc_q <= `TJMD_RST_BYTE;
			upper_accumulator_q <= `TJMD_RST_BYTE;
			timer_overflow_flag_q <= 1'b0;
			user_flag_zero_q <= 1'b0;
			user_flag_one_q <= 1'b0;
			upper_flag_q <= 1'b0;
			illegal_q <= 1'b0;
			working_register_q <= 64'h0;
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			cursor_wr_q <= 1'b0;
			home_wr_q <= 1'b0;
			display_memory_start_wr_q <= 1'b0;
			attribute_latch_zero_wr_q <= 1'b0;
			attribute_latch_one_wr_q <= 1'b0;
			baud_select_wr_q <= 1'b0;
			pair_wdata_q <= 16'h0000;
			byte_wdata_q <= `TJMD_RST_BYTE;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			arg_q <= arg_d;
			pc_q <= pc_d;
			acc_q <= acc_d;
			upper_accumulator_q <= upper_accumulator_d;
			timer_overflow_flag_q <= timer_overflow_flag_d;
			user_flag_zero_q <= user_flag_zero_d;
			user_flag_one_q <= user_flag_one_d;
			upper_flag_q <= upper_flag_d;
			illegal_q <= illegal_d;
			working_register_q <= working_register_d;
			pin_meta_q <= external_interrupt_pin;
			pin_sync_q <= pin_meta_q;
			cursor_wr_q <= cursor_wr_d;
			home_wr_q <= home_wr_d;
			display_memory_start_wr_q <= display_memory_start_wr_d;
			attribute_latch_zero_wr_q <= attribute_latch_zero_wr_d;
			attribute_latch_one_wr_q <= attribute_latch_one_wr_d;
			baud_select_wr_q <= baud_select_wr_d;
			// write data stand with the strobe and hold until the next move
			if (cursor_wr_d || home_wr_d || display_memory_start_wr_d) begin
				pair_wdata_q <= {upper_accumulator_q, acc_q};
			end
			if (attribute_latch_zero_wr_d || attribute_latch_one_wr_d || baud_select_wr_d) begin
				byte_wdata_q <= acc_q;
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/tjmd_map.vh ----
// register offsets, opcodes, field positions and reset values of the jump/move decoder
`ifndef TJMD_MAP_VH
`define TJMD_MAP_VH

// ********************************************************************
// register byte offsets (12-bit bus address)
// ********************************************************************
`define TJMD_OFF_CMD 12'h000
`define TJMD_OFF_STATUS 12'h004
`define TJMD_OFF_PC 12'h008
`define TJMD_OFF_ACC 12'h00c
`define TJMD_OFF_FLAGS 12'h010
`define TJMD_OFF_WREG 12'h020
`define TJMD_OFF_WREG_END 12'h03c
`define TJMD_OFF_DMEM 12'h100
`define TJMD_OFF_DMEM_END 12'h1fc

// ********************************************************************
// field positions
// ********************************************************************
`define TJMD_ST_BUSY 0
`define TJMD_ST_TMRF 1
`define TJMD_ST_UF0 2
`define TJMD_ST_UF1 3
`define TJMD_ST_HFLAG 4
`define TJMD_ST_XPIN 5
`define TJMD_ST_ILLEGAL 6
`define TJMD_FL_UF0 0
`define TJMD_FL_UF1 1

// ********************************************************************
// reset values and bus responses
// ********************************************************************
`define TJMD_RST_PC 13'h0000
`define TJMD_RST_BYTE 8'h00
`define TJMD_RESP_OKAY 2'b00
`define TJMD_RESP_SLVERR 2'b10

// ********************************************************************
// opcodes: moves
// ********************************************************************
`define TJMD_OP_A_CURSOR 8'h9b
`define TJMD_OP_A_HOME 8'h9a
`define TJMD_OP_A_UPPER 8'he2
`define TJMD_OP_A_HPOS 8'h3f
`define TJMD_OP_A_VPOS 8'h3e
`define TJMD_OP_A_IRQ 8'h8c
`define TJMD_OP_A_STW 8'hc7
`define TJMD_OP_A_STAT 8'h9c
`define TJMD_OP_A_T 8'h42
`define TJMD_OP_A_IMM 8'h23
`define TJMD_OP_ATTR0_A 8'h3c
`define TJMD_OP_ATTR1_A 8'h3d
`define TJMD_OP_BAUD_A 8'h02
`define TJMD_OP_DSTART_A 8'h0d
`define TJMD_OP_CURSOR_A 8'h8b
`define TJMD_OP_HOME_A 8'h8a
`define TJMD_OP_A_WREG_HI 5'h1f
`define TJMD_OP_A_IND_HI 7'h78

// ********************************************************************
// opcodes: within-page jumps
// ********************************************************************
`define TJMD_OP_JMP_TCLR 8'h06
`define TJMD_OP_JMP_TSET 8'h16
`define TJMD_OP_JMP_AZ 8'hc6
`define TJMD_OP_JMP_ANZ 8'h96
`define TJMD_OP_JF0 8'hb6
`define TJMD_OP_JNF0 8'ha6
`define TJMD_OP_JF1 8'h76
`define TJMD_OP_JNF1 8'h66
`define TJMD_OP_JXI 8'h86
`define TJMD_OP_JNXI 8'h56

`endif

// ---- src/tjmd_dmem.v ----
// 64 x 8 data memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module tjmd_dmem (
	input wire mclk,
	input wire we,
	input wire [5:0] waddr,
	input wire [7:0] wdata,
	input wire [5:0] raddr,
	output reg [7:0] rdata_q
);
	reg [7:0] mem [0:63];

	always @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule
`default_nettype wire

// ---- src/tjmd_axil.v ----
// axi4-lite slave front end: holds address and data, hands the core one write and one read at a time, which may coincide
`timescale 1ns/1ns
`default_nettype none
`include "tjmd_map.vh"
module tjmd_axil (
	input wire mclk,
	input wire rst_n,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire wr_en,
	output wire [11:0] wr_addr,
	output wire [31:0] wr_data,
	output wire [3:0] wr_strb,
	input wire wr_ok,
	output wire [11:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_ok
);
	reg aw_held_q;
	reg w_held_q;
	reg [11:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg ar_pend_q;
	reg [11:0] araddr_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;

	// no new address is taken while a response is still waiting
	assign s_axi_awready = ~aw_held_q & ~bvalid_q;
	assign s_axi_wready = ~w_held_q & ~bvalid_q;
	assign s_axi_arready = ~ar_pend_q & ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_en = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;
	assign rd_addr = araddr_q;

	always @(posedge mclk) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `TJMD_RESP_OKAY;
			ar_pend_q <= 1'b0;
			araddr_q <= 12'h000;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `TJMD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? `TJMD_RESP_OKAY : `TJMD_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				ar_pend_q <= 1'b1;
				araddr_q <= s_axi_araddr;
			end
			if (ar_pend_q) begin
				ar_pend_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_ok ? rd_data : 32'h0000_0000;
				rresp_q <= rd_ok ? `TJMD_RESP_OKAY : `TJMD_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- sim/tjmd_core_checker.sv ----
// port-level assertions for the jump/move decoder core
`timescale 1ns/1ns
`default_nettype none
module tjmd_core_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic cursor_wr_q,
	input wire logic home_wr_q,
	input wire logic display_memory_start_wr_q,
	input wire logic [15:0] pair_wdata_q,
	input wire logic attribute_latch_zero_wr_q,
	input wire logic attribute_latch_one_wr_q,
	input wire logic baud_select_wr_q,
	input wire logic [7:0] byte_wdata_q
);
	// ****************************************************************
	// strobe groups
	// ****************************************************************
	wire [2:0] pair_s = {cursor_wr_q, home_wr_q, display_memory_start_wr_q};
	wire [2:0] byte_s = {attribute_latch_zero_wr_q, attribute_latch_one_wr_q, baud_select_wr_q};
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_PAIR_ONEHOT: assert property ($onehot0(pair_s))
		else $error("pair strobes overlap");
	AST_PAIR_PULSE: assert property (|pair_s |=> pair_s == 3'b000)
		else $error("pair strobe longer than one cycle");
	// data only moves with its strobe, so a listener may sample it late
	AST_PAIR_HOLD: assert property (pair_s == 3'b000 |-> $stable(pair_wdata_q))
		else $error("pair data changed without strobe");
	AST_BYTE_ONEHOT: assert property ($onehot0(byte_s))
		else $error("byte strobes overlap");
	AST_BYTE_PULSE: assert property (|byte_s |=> byte_s == 3'b000)
		else $error("byte strobe longer than one cycle");
	AST_BYTE_HOLD: assert property (byte_s == 3'b000 |-> $stable(byte_wdata_q))
		else $error("byte data changed without strobe");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
	AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
endmodule
bind tjmd_core tjmd_core_checker i_tjmd_core_checker (.mclk(mclk), .rst_n(rst_n),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.cursor_wr_q(cursor_wr_q), .home_wr_q(home_wr_q), .pair_wdata_q(pair_wdata_q),
	.display_memory_start_wr_q(display_memory_start_wr_q), .byte_wdata_q(byte_wdata_q),
	.attribute_latch_zero_wr_q(attribute_latch_zero_wr_q), .baud_select_wr_q(baud_select_wr_q),
	.attribute_latch_one_wr_q(attribute_latch_one_wr_q));
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the jump/move decoder core over axi4-lite
`timescale 1ns/1ns
`default_nettype none
module testbench;
	reg mclk, rst_n, awv, wv, bry, arv, rry, tov, xpin;
	reg [11:0] awa, ara;
	reg [31:0] wd, td;
	reg [1:0] tr;
	reg [6:0] hp;
	reg [4:0] vp;
	reg [5:0] st;
	reg [5:0] seen = 6'h00;
	reg [7:0] ir, ps, tc;
	reg [15:0] cu, ho;
	wire awr, wrd, bv, arr, rv, cw, hw, dw, a0, a1, bw;
	wire [1:0] br, rr;
	wire [31:0] rdt;
	wire [15:0] pd;
	wire [7:0] bd;
	integer n_mismatch = 0;
	integer comparisons = 0;
	integer ns = 0;
	tjmd_core i_tjmd_core (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .timer_overflow_set(tov),
		.external_interrupt_pin(xpin), .cursor_address_reg(cu), .home_address_reg(ho),
		.horizontal_pen_position(hp), .vertical_pen_position(vp), .serial_status_latch(st),
		.interrupt_pending_reg(ir), .program_status_word(ps), .timer_count(tc),
		.cursor_wr_q(cw), .home_wr_q(hw), .display_memory_start_wr_q(dw), .pair_wdata_q(pd),
		.attribute_latch_zero_wr_q(a0), .attribute_latch_one_wr_q(a1),
		.baud_select_wr_q(bw), .byte_wdata_q(bd));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// strobes last one cycle, so latch the last one seen and count them
	always @(posedge mclk) begin
		if (|{cw, hw, dw, a0, a1, bw}) begin
			seen <= {cw, hw, dw, a0, a1, bw};
			ns <= ns + 1;
		end
	end
	// ****************************************************************
	// bus and check tasks
	// ****************************************************************
	task report_and_stop;
		begin
			$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
			if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	task ck(input string n, input [31:0] e, input [31:0] s);
		begin
			comparisons++;
			if (s !== e) begin
				n_mismatch++;
				$display("BAD %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		reg pa, pw;
		begin
			@(posedge mclk);
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			pa = 1'b1;
			pw = 1'b1;
			while (pa | pw) begin
				@(posedge mclk);
				pa = pa & ~awr;
				pw = pw & ~wrd;
				awv <= pa;
				wv <= pw;
			end
			do @(posedge mclk); while (bv !== 1'b1);
			bry <= 1'b1;
			do @(posedge mclk); while (bv !== 1'b1);
			ck("bresp", 32'h0, {30'h0, br});
			bry <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, output [31:0] d, output [1:0] r);
		begin
			@(posedge mclk);
			ara <= a;
			arv <= 1'b1;
			do @(posedge mclk); while (arr !== 1'b1);
			arv <= 1'b0;
			do @(posedge mclk); while (rv !== 1'b1);
			rry <= 1'b1;
			do @(posedge mclk); while (rv !== 1'b1);
			d = rdt;
			r = rr;
			rry <= 1'b0;
		end
	endtask
	task rc(input string n, input [11:0] a, input [31:0] m, input [31:0] e);
		reg [31:0] d;
		reg [1:0] r;
		begin
			rd(a, d, r);
			ck(n, e, d & m);
		end
	endtask
	task c(input [7:0] op, input [7:0] o);
		reg [31:0] d;
		reg [1:0] r;
		begin
			wr(12'h000, {16'h0000, o, op});
			d = 32'h0000_0001;
			while (d[0] !== 1'b0) rd(12'h004, d, r);
		end
	endtask
	task cr(input [7:0] op, input [7:0] o, input [7:0] e);
		begin
			c(op, o);
			rc("acc", 12'h00c, 32'h0000_00ff, {24'h000000, e});
		end
	endtask
	task jp(input [7:0] op, input [7:0] o, input [12:0] e);
		begin
			c(op, o);
			rc("pc", 12'h008, 32'h0000_1fff, {19'h00000, e});
		end
	endtask
	task mv(input [7:0] op, input [5:0] e);
		integer n0;
		begin
			n0 = ns;
			c(op, 8'h00);
			ck("strobe count", n0 + 1, ns);
			ck("strobe", {26'h0000000, e}, {26'h0000000, seen});
		end
	endtask
	task tp;
		begin
			@(posedge mclk);
			tov <= 1'b1;
			@(posedge mclk);
			tov <= 1'b0;
		end
	endtask
	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		{rst_n, awv, wv, bry, arv, rry, tov, xpin} = 8'h00;
		{awa, ara, wd} = 56'h0;
		{hp, vp, st, ir, ps, tc} = {7'h55, 5'h0a, 6'h2a, 8'h81, 8'h5c, 8'h3c};
		{cu, ho} = {16'h1234, 16'h00c3};
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		wr(12'h008, 32'h0000_1234);
		jp(8'h23, 8'hff, 13'h1236);
		cr(8'h3f, 8'h00, 8'h55);
		cr(8'h23, 8'hff, 8'hff);
		cr(8'h3e, 8'h00, 8'h0a);
		cr(8'h9c, 8'h00, 8'hea);
		cr(8'h8c, 8'h00, 8'h81);
		cr(8'hc7, 8'h00, 8'h5c);
		cr(8'h42, 8'h00, 8'h3c);
		wr(12'h008, 32'h0000_1234);
		jp(8'h96, 8'h40, 13'h1240);
		jp(8'hc6, 8'h77, 13'h1242);
		cr(8'h23, 8'h00, 8'h00);
		jp(8'hc6, 8'h77, 13'h1277);
		jp(8'h96, 8'h40, 13'h1279);
		tp();
		rc("timer flag", 12'h004, 32'h2, 32'h2);
		jp(8'h16, 8'h10, 13'h1210);
		rc("timer flag", 12'h004, 32'h2, 32'h0);
		jp(8'h16, 8'h10, 13'h1212);
		jp(8'h06, 8'h30, 13'h1230);
		tp();
		jp(8'h06, 8'h30, 13'h1232);
		rc("timer flag", 12'h004, 32'h2, 32'h0);
		cr(8'h23, 8'h69, 8'h69);
		mv(8'h3c, 6'h04);
		ck("byte data", 32'h69, {24'h000000, bd});
		mv(8'h3d, 6'h02);
		mv(8'h02, 6'h01);
		c(8'h9b, 8'h00);
		rc("pair", 12'h00c, 32'hffff, 32'h1234);
		rc("upper flag", 12'h004, 32'h10, 32'h10);
		cr(8'he2, 8'h00, 8'h12);
		c(8'h9a, 8'h00);
		rc("pair", 12'h00c, 32'hffff, 32'h00c3);
		rc("upper flag", 12'h004, 32'h10, 32'h0);
		mv(8'h8b, 6'h20);
		ck("pair data", 32'h00c3, {16'h0000, pd});
		mv(8'h8a, 6'h10);
		mv(8'h0d, 6'h08);
		wr(12'h020, 32'h6);
		wr(12'h024, 32'h5);
		wr(12'h118, 32'ha7);
		wr(12'h114, 32'h3c);
		cr(8'hf1, 8'h00, 8'h3c);
		cr(8'hf0, 8'h00, 8'ha7);
		wr(12'h02c, 32'h9e);
		cr(8'hfb, 8'h00, 8'h9e);
		wr(12'h008, 32'h0000_1234);
		wr(12'h010, 32'h1);
		jp(8'hb6, 8'h51, 13'h1251);
		jp(8'h66, 8'h60, 13'h1260);
		jp(8'h76, 8'h70, 13'h1262);
		jp(8'ha6, 8'h80, 13'h1264);
		xpin <= 1'b1;
		rc("ext pin", 12'h004, 32'h20, 32'h20);
		jp(8'h86, 8'h20, 13'h1220);
		jp(8'h56, 8'h30, 13'h1222);
		c(8'h00, 8'h00);
		rc("illegal", 12'h004, 32'h40, 32'h40);
		rc("pc held", 12'h008, 32'h1fff, 32'h1222);
		rd(12'h800, td, tr);
		ck("unmapped resp", 32'h2, {30'h0, tr});
		report_and_stop();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (30000) @(posedge mclk);
		n_mismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
